/* File: shared/pwm_regs.vh */
// Register map, reset values and counter limits of the dual PWM block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// Printed offsets are register indices; byte address is four times each
`define IDX_DUTY_CH0      8'hfc
`define IDX_DUTY_CH1      8'hfd
`define IDX_PRESCALE      8'hfe
`define ADDR_DUTY_CH0     10'h3f0
`define ADDR_DUTY_CH1     10'h3f4
`define ADDR_PRESCALE     10'h3f8
`define ADDR_W            10

`define RST_DUTY_CH0      8'h00
`define RST_DUTY_CH1      8'h00
`define RST_PRESCALE      8'h00
`define CNT_LAST          8'hfe

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: logic/dual_pwm_generator.v */
// Dual pulse-width generator with AXI4-Lite register access.
// Assumes one system clock, synchronous active-low reset, single master.
// Overview of operation
// [R1] Two channels share one 8-bit prescaler and one 8-bit counter.
// [R2] The prescaler tick is the counter's advance enable.
// [R3] The counter runs 0 to 254 and wraps, a period of 255 steps.
// [R4] An output is low while its compare value exceeds the counter.
// [R5] An output is high while its compare value is at or below it.
// [R6] The prescaler divides the clock by reload plus one.
// [R7] Output period is (reload plus one) times 255 clocks.
// [R8] Compare zero gives constant high, all ones constant low.
// [R9] A new compare value acts on the very next comparison.
// [R10] Reading the prescaler register returns the reload, not the count.
// [R11] Reset clears the prescaler reload and channel-zero compare.
// [R12] The prescaler counts clocks, ticks at the factor, then restarts.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"

module dual_pwm_generator
(
    input  wire        I_CLK,
    input  wire        I_NRST,
    input  wire [9:0]  I_AWADDR,
    input  wire [2:0]  I_AWPROT,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [9:0]  I_ARADDR,
    input  wire [2:0]  I_ARPROT,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    output reg         O_CHANNEL_OUTPUT_0_N,
    output reg         O_CHANNEL_OUTPUT_1_N
);

    reg  [7:0]  duty_ch0_r;
    reg  [7:0]  duty_ch1_r;
    reg  [7:0]  prescale_r;
    reg  [7:0]  pre_cnt_r;
    reg  [7:0]  cnt_r;
    reg         aw_held_r;
    reg  [9:0]  aw_addr_r;
    reg         w_held_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;

    wire        tick;
    wire [7:0]  pre_cnt_nxt;
    wire [7:0]  cnt_nxt;
    wire        wr_go;
    wire        wr_hit;
    wire        wr_duty0;
    wire        wr_duty1;
    wire        wr_prescale;
    wire        high0;
    wire        high1;
    reg  [31:0] rd_nxt;
    reg         rd_hit;

    // Prescaler counts down from the reload and ticks at zero; a reload
    // lowered mid-count then acts at the next restart, where an up-count
    // compared against it would run on through the 8-bit wrap
    assign tick        = (pre_cnt_r == 8'h00);              // [R6] [R12]
    assign pre_cnt_nxt = pre_cnt_r - 8'h01;

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            pre_cnt_r <= 8'h00;
        end
        else if (tick)
        begin
            pre_cnt_r <= prescale_r;                        // [R12]
        end
        else
        begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // Shared counter, modulo 255
    assign cnt_nxt = (cnt_r == `CNT_LAST) ? 8'h00           // [R3]
                                          : cnt_r + 8'h01;

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            cnt_r <= 8'h00;
        end
        else if (tick)
        begin
            cnt_r <= cnt_nxt;                               // [R1] [R2] [R7]
        end
    end

    // Outputs compare against the live register, so a write acts at once;
    // the counter never reaches 0xff, which keeps compare 0xff always low
    duty_compare_stage
    #(
        .W          (8)
    )
    cmp0
    (
        .i_duty     (duty_ch0_r),
        .i_count    (cnt_r),
        .o_high     (high0)
    );

    duty_compare_stage
    #(
        .W          (8)
    )
    cmp1
    (
        .i_duty     (duty_ch1_r),
        .i_count    (cnt_r),
        .o_high     (high1)
    );

    // Pins idle high through reset, the inactive level of the driver
    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_CHANNEL_OUTPUT_0_N <= 1'b1;
            O_CHANNEL_OUTPUT_1_N <= 1'b1;
        end
        else
        begin
            O_CHANNEL_OUTPUT_0_N <= high0;                  // [R4] [R5] [R9]
            O_CHANNEL_OUTPUT_1_N <= high1;                  // [R4] [R5] [R9]
        end
    end

    // Write channel: address and data latched in either order
    assign wr_go  = aw_held_r && w_held_r && !O_BVALID;
    assign wr_hit = (aw_addr_r == `ADDR_DUTY_CH0) ||
                    (aw_addr_r == `ADDR_DUTY_CH1) ||
                    (aw_addr_r == `ADDR_PRESCALE);

    // Address side; held until the response is launched
    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_AWREADY <= 1'b0;
            aw_held_r <= 1'b0;
            aw_addr_r <= 10'h000;
        end
        else
        begin
            O_AWREADY <= 1'b0;
            if (I_AWVALID && !aw_held_r && !O_AWREADY)
            begin
                O_AWREADY <= 1'b1;
                aw_held_r <= 1'b1;
                aw_addr_r <= {I_AWADDR[9:2], 2'b00};
            end
            else if (wr_go)
            begin
                aw_held_r <= 1'b0;
            end
        end
    end

    // Data side; held until the response is launched
    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_WREADY <= 1'b0;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            O_WREADY <= 1'b0;
            if (I_WVALID && !w_held_r && !O_WREADY)
            begin
                O_WREADY <= 1'b1;
                w_held_r <= 1'b1;
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
            end
            else if (wr_go)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Response; launched once both halves are in, held until taken
    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_BVALID <= 1'b0;
            O_BRESP  <= `RESP_OKAY;
        end
        else if (wr_go)
        begin
            O_BVALID <= 1'b1;
            O_BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (O_BVALID && I_BREADY)
        begin
            O_BVALID <= 1'b0;
        end
    end

    // Register store; only byte lane 0 carries data
    assign wr_duty0    = wr_go && w_strb_r[0] &&
                         (aw_addr_r == `ADDR_DUTY_CH0);
    assign wr_duty1    = wr_go && w_strb_r[0] &&
                         (aw_addr_r == `ADDR_DUTY_CH1);
    assign wr_prescale = wr_go && w_strb_r[0] &&
                         (aw_addr_r == `ADDR_PRESCALE);

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            duty_ch0_r <= `RST_DUTY_CH0;                    // [R11]
        end
        else if (wr_duty0)
        begin
            duty_ch0_r <= w_data_r[7:0];                    // [R9]
        end
    end

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            duty_ch1_r <= `RST_DUTY_CH1;
        end
        else if (wr_duty1)
        begin
            duty_ch1_r <= w_data_r[7:0];                    // [R9]
        end
    end

    // A new reload is picked up by the prescaler at its next restart
    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            prescale_r <= `RST_PRESCALE;                    // [R11]
        end
        else if (wr_prescale)
        begin
            prescale_r <= w_data_r[7:0];                    // [R6]
        end
    end

    // Read decode; the running prescaler count has no address
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({I_ARADDR[9:2], 2'b00})
            `ADDR_DUTY_CH0: rd_nxt = {24'h000000, duty_ch0_r};
            `ADDR_DUTY_CH1: rd_nxt = {24'h000000, duty_ch1_r};
            `ADDR_PRESCALE: rd_nxt = {24'h000000, prescale_r}; // [R10]
            default:        rd_hit = 1'b0;
        endcase
    end

    always @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0000_0000;
            O_RRESP   <= `RESP_OKAY;
        end
        else
        begin
            O_ARREADY <= 1'b0;
            if (I_ARVALID && !O_ARREADY && !O_RVALID)
            begin
                O_ARREADY <= 1'b1;
                O_RVALID  <= 1'b1;
                O_RDATA   <= rd_nxt;
                O_RRESP   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (O_RVALID && I_RREADY)
            begin
                O_RVALID <= 1'b0;
            end
        end
    end

endmodule // dual_pwm_generator

// Comparator of one channel; high means the pin stands high
module duty_compare_stage
#(
    parameter W = 8
)
(
    input  wire [W-1:0] i_duty,
    input  wire [W-1:0] i_count,
    output wire         o_high
);

    // Compare value strictly above the count pulls the pin low
    assign o_high = !(i_duty > i_count);                // [R4] [R5] [R8]

endmodule // duty_compare_stage
`default_nettype wire

/* File: bench/dual_pwm_generator_checker.sv */
// Checks on bus answers and duty writes of the dual PWM block.
// Assumes binding to the top module; reset is sync, active low.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module dual_pwm_generator_checker
(
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    input wire logic [9:0]  I_AWADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0]  I_WSTRB,
    input wire logic        I_BREADY,
    input wire logic        O_AWREADY,
    input wire logic        O_WREADY,
    input wire logic [1:0]  O_BRESP,
    input wire logic        O_BVALID,
    input wire logic [31:0] O_RDATA,
    input wire logic        O_RVALID,
    input wire logic        O_CHANNEL_OUTPUT_0_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    // Duty write taken now; the pin shows it two edges later
    wire logic w0 = O_AWREADY && O_WREADY && I_WSTRB[0]
        && I_AWADDR == `ADDR_DUTY_CH0;
    property p_ff; w0 && I_WDATA[7:0] == 8'hff |=> ##1
        (!O_CHANNEL_OUTPUT_0_N)[*4]; endproperty
    a_ff: assert property (p_ff) else $error("duty ff");
    property p_z; w0 && I_WDATA[7:0] == 8'h00 |=> ##1
        O_CHANNEL_OUTPUT_0_N[*4]; endproperty
    a_z: assert property (p_z) else $error("duty 0");
    property p_ab; O_AWREADY && O_WREADY |=> O_BVALID; endproperty
    a_ab: assert property (p_ab) else $error("no bvalid");
    property p_bh; O_BVALID && !I_BREADY |=> $stable(O_BRESP); endproperty
    a_bh: assert property (p_bh) else $error("bresp");
    property p_b1; O_BVALID && I_BREADY |=> !O_BVALID; endproperty
    a_b1: assert property (p_b1) else $error("bvalid");
    property p_aw; $rose(O_AWREADY) |=> !O_AWREADY; endproperty
    a_aw: assert property (p_aw) else $error("awready");
    property p_wp; $rose(O_WREADY) |=> !O_WREADY; endproperty
    a_wp: assert property (p_wp) else $error("wready");
    property p_hi; O_RVALID |-> O_RDATA[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("rdata");
    c_wr: cover property (w0);
    c_rd: cover property (O_RVALID);
    c_fl: cover property ($fell(O_CHANNEL_OUTPUT_0_N));
endmodule // dual_pwm_generator_checker
bind dual_pwm_generator dual_pwm_generator_checker chk (.I_CLK, .I_NRST,
    .I_AWADDR, .I_WDATA, .I_WSTRB, .I_BREADY, .O_AWREADY, .O_WREADY,
    .O_BRESP, .O_BVALID, .O_RDATA, .O_RVALID, .O_CHANNEL_OUTPUT_0_N);
`default_nettype wire

/* File: bench/pwm_filter_model.sv */
// Integrator on the PWM pins: counts low clocks per channel.
// Assumes the bench clears it, then waits one whole period.
`timescale 1ns/1ps
`default_nettype none
module pwm_filter_model
(
    input  wire logic i_clk,
    input  wire logic i_clr,
    input  wire logic i_out0_n,
    input  wire logic i_out1_n,
    output var  int   o_low0,
    output var  int   o_low1
);
    // Low time over a period stands for the filtered voltage
    always @(posedge i_clk)
    begin
        o_low0 <= i_clr ? 0 : o_low0 + int'(!i_out0_n);
        o_low1 <= i_clr ? 0 : o_low1 + int'(!i_out1_n);
    end
endmodule // pwm_filter_model
`default_nettype wire

/* File: bench/dual_pwm_generator_tb.sv */
// Self-checking bench of the dual PWM block over AXI4-Lite.
// Assumes the register header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_regs.vh"
module dual_pwm_generator_tb;
    logic I_CLK, I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID;
    logic I_RREADY, clr;
    logic [9:0] I_AWADDR, I_ARADDR;
    logic [31:0] I_WDATA;
    wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    wire logic O_CHANNEL_OUTPUT_0_N, O_CHANNEL_OUTPUT_1_N;
    wire logic [1:0] O_BRESP, O_RRESP;
    wire logic [31:0] O_RDATA;
    int low0, low1, n_mismatch, n_compared;
    dual_pwm_generator dut (.I_CLK, .I_NRST, .I_AWADDR, .I_AWPROT(3'h0),
        .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB(4'hf), .I_WVALID,
        .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR,
        .I_ARPROT(3'h0), .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP,
        .O_RVALID, .I_RREADY, .O_CHANNEL_OUTPUT_0_N, .O_CHANNEL_OUTPUT_1_N);
    pwm_filter_model filt (.i_clk(I_CLK), .i_clr(clr),
        .i_out0_n(O_CHANNEL_OUTPUT_0_N), .i_out1_n(O_CHANNEL_OUTPUT_1_N),
        .o_low0(low0), .o_low1(low1));
    initial
    begin
        I_CLK = 0;
        forever #12.5 I_CLK = ~I_CLK;
    end
    task automatic chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One write (w=1) or read; d is the data sent or expected
    task automatic acc(input bit w, input logic [9:0] a,
        input logic [7:0] d, input logic [1:0] r);
        @(posedge I_CLK);
        I_AWADDR <= a;
        I_ARADDR <= a;
        I_WDATA <= {24'h0, d};
        {I_AWVALID, I_WVALID, I_BREADY} <= {3{w}};
        {I_ARVALID, I_RREADY} <= {2{!w}};
        repeat (20)
        begin
            @(posedge I_CLK);
            if (O_AWREADY) I_AWVALID <= 0;
            if (O_WREADY) I_WVALID <= 0;
            if (O_ARREADY) I_ARVALID <= 0;
            if (O_BVALID || O_RVALID)
            begin
                {I_BREADY, I_RREADY} <= 2'b00;
                chk({30'h0, w ? O_BRESP : O_RRESP}, {30'h0, r});
                if (!w) chk(O_RDATA, {24'h0, d});
                return;
            end
        end
        n_mismatch++;
        $display("CHECK FAILED %0t bus timeout", $time);
        end_of_test();
    endtask
    // Clocks from one fall of channel 0 to the next
    task automatic per(input int e);
        int n, s, f;
        logic q;
        f = 0;
        s = 0;
        q = 1'b0;
        for (n = 0; n < 2000 && f < 2; n++)
        begin
            @(posedge I_CLK);
            if (q && !O_CHANNEL_OUTPUT_0_N)
            begin
                f++;
                if (f == 2) chk(n - s, e);
                s = n;
            end
            q = O_CHANNEL_OUTPUT_0_N;
        end
        if (f < 2)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t no period", $time);
            end_of_test();
        end
    endtask
    // Low clocks of each pin over a window of w clocks
    task automatic meas(input int w, e0, e1);
        repeat (8) @(posedge I_CLK);
        clr <= 1;
        @(posedge I_CLK);
        clr <= 0;
        repeat (w) @(posedge I_CLK);
        #1;
        chk(low0, e0);
        chk(low1, e1);
    endtask
    initial
    begin
        {I_NRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 0;
        {I_AWADDR, I_ARADDR, I_WDATA, clr} = 0;
        repeat (6) @(posedge I_CLK);
        I_NRST <= 1;
        acc(0, `ADDR_DUTY_CH0, 8'h00, `RESP_OKAY);
        acc(0, `ADDR_DUTY_CH1, 8'h00, `RESP_OKAY);
        acc(0, `ADDR_PRESCALE, 8'h00, `RESP_OKAY);
        acc(1, `ADDR_PRESCALE, 8'h01, `RESP_OKAY);
        acc(0, `ADDR_PRESCALE, 8'h01, `RESP_OKAY);
        acc(1, 10'h3fc, 8'h5a, `RESP_SLVERR);
        acc(0, 10'h3fc, 8'h00, `RESP_SLVERR);
        acc(1, `ADDR_DUTY_CH0, 8'h03, `RESP_OKAY);
        acc(1, `ADDR_DUTY_CH1, 8'h80, `RESP_OKAY);
        meas(510, 6, 256);
        per(510);
        acc(1, `ADDR_PRESCALE, 8'h00, `RESP_OKAY);
        per(255);
        acc(1, `ADDR_DUTY_CH0, 8'hff, `RESP_OKAY);
        acc(1, `ADDR_DUTY_CH1, 8'h00, `RESP_OKAY);
        meas(255, 255, 0);
        acc(1, `ADDR_DUTY_CH0, 8'h00, `RESP_OKAY);
        meas(255, 0, 0);
        acc(1, `ADDR_PRESCALE, 8'h07, `RESP_OKAY);
        acc(1, `ADDR_DUTY_CH0, 8'h40, `RESP_OKAY);
        @(posedge I_CLK);
        I_NRST <= 0;
        repeat (2) @(posedge I_CLK);
        I_NRST <= 1;
        acc(0, `ADDR_PRESCALE, 8'h00, `RESP_OKAY);
        acc(0, `ADDR_DUTY_CH0, 8'h00, `RESP_OKAY);
        end_of_test();
    end
endmodule // dual_pwm_generator_tb
`default_nettype wire
